/* File: core/tsr_pkg.sv */
// package: constants, states and carriers of the temperature sensor register map
package tsr_pkg;
   // -----------------------------------------------------------------
   // select index codes
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_TEMP = 8'h00;
   localparam logic [7:0] IDX_CFG_LIVE = 8'h01;
   localparam logic [7:0] IDX_LOW_LIVE = 8'h02;
   localparam logic [7:0] IDX_HIGH_LIVE = 8'h03;
   localparam logic [7:0] IDX_CFG_STORED = 8'h11;
   localparam logic [7:0] IDX_LOW_STORED = 8'h12;
   localparam logic [7:0] IDX_HIGH_STORED = 8'h13;
   localparam logic [7:0] IDX_RESET = 8'h00;
   localparam logic [2:0] IDX_UPPER_ZERO = 3'h0;
   // -----------------------------------------------------------------
   // reset and factory values
   // -----------------------------------------------------------------
   localparam logic [15:0] TEMP_RESET = 16'h0000;
   localparam logic [15:0] CFG_FACTORY = 16'h0000;
   localparam logic [15:0] LOW_FACTORY = 16'h4B00;
   localparam logic [15:0] HIGH_FACTORY = 16'h5000;
   // -----------------------------------------------------------------
   // serial framing
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_PREFIX = 4'h9;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // serial engine states, gray coded along the usual path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_ACK = 3'h3,
      ST_RX = 3'h2,
      ST_RX_ACK = 3'h6,
      ST_TX = 3'h7,
      ST_TX_ACK = 3'h5
   } tsr_state_t;
   // live register set that the monitoring logic uses
   typedef struct packed {
      logic [15:0] config_live;
      logic [15:0] low_limit_live;
      logic [15:0] high_limit_live;
   } tsr_live_t;
endpackage : tsr_pkg

/* File: core/tsr_regs.sv */
// two-wire temperature sensor register map with select index and serial engine
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RULE_01] master loads select index before data access
// [RULE_02] reset copies stored values into live registers
// [RULE_03] live and stored writable separately unless locked
// [RULE_04] monitoring uses only live register values
// [RULE_05] index codes 00,01-03,11-13 select registers
// [RULE_06] index 8-bit write-only; data 16-bit
// [RULE_07] index resets to temperature reading
// [RULE_08] upper-byte-only configuration accesses accepted
// [RULE_09] index kept across read transactions
// [RULE_10] master refreshes index in every write
// [RULE_11] first written byte becomes select index
// [RULE_12] only five low index bits select
// [RULE_13] nonzero upper bits may be a command
// [RULE_14] unlisted index byte leaves index unchanged
// [RULE_15] invalid index byte answered with NACK
// [RULE_16] start, address, ACK, then index byte
// [RULE_17] address 1001 plus straps, acknowledged on match
// [RULE_18] device drives ACK after matching address
// [RULE_19] one conversion right after reset
// [RULE_20] read address direction one, upper byte first
// [RULE_21] temperature writes ignored, data bytes NACKed
// [RULE_22] write upper then lower, update per byte
module tsr_regs (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   // two-wire pins, open drain data
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic [2:0] i_strapped_address_inputs,
   // lock and conversion side
   input wire logic i_lock,
   input wire logic [15:0] i_temp_data,
   input wire logic i_temp_valid,
   output logic o_conv_start,
   // live values and command bytes
   output tsr_pkg::tsr_live_t o_live,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_code
);
   import tsr_pkg::*;

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   // [RULE_06] index 8 bits, data words 16
   logic [7:0] index_reg; // write-only select index
   logic [15:0] temp_reg; // temperature reading
   tsr_live_t live_reg; // live copies
   tsr_live_t stored_reg; // nonvolatile copies
   logic conv_first_reg; // conversion still owed after reset
   logic conv_reg;
   logic cmd_valid_reg;
   logic [7:0] cmd_code_reg;

   // -----------------------------------------------------------------
   // serial engine state
   // -----------------------------------------------------------------
   tsr_state_t state_reg;
   logic scl_q_reg; // previous clock sample for edges
   logic sda_q_reg; // previous data sample
   logic [7:0] shift_reg; // receive shifter
   logic [7:0] tx_reg; // transmit shifter
   logic [3:0] cnt_reg; // bits in this byte
   logic rw_reg; // direction bit of the address
   logic first_reg; // next received byte is the index
   logic hi_reg; // next data byte is the upper byte
   logic oe_reg;
   logic sda_out_reg;

   // bus events from sampled pins
   logic scl_rise, scl_fall, start_ev, stop_ev, byte_done;
   assign scl_rise = i_scl && !scl_q_reg;
   assign scl_fall = !i_scl && scl_q_reg;
   assign start_ev = i_scl && scl_q_reg && sda_q_reg && !i_sda;
   assign stop_ev = i_scl && scl_q_reg && !sda_q_reg && i_sda;
   assign byte_done = (state_reg == ST_RX) && scl_fall && (cnt_reg == BITS_PER_BYTE);

   // address match on prefix and straps
   logic addr_match;
   // [RULE_17] prefix and strap compare
   assign addr_match = (shift_reg[7:4] == ADDR_PREFIX) &&
                       (shift_reg[3:1] == i_strapped_address_inputs);

   // index decode; upper bits must be zero for a register
   function automatic logic idx_valid(input logic [7:0] idx);
      // [RULE_05] listed codes only
      // [RULE_12] every listed code has zero upper bits
      case (idx)
         IDX_TEMP, IDX_CFG_LIVE, IDX_LOW_LIVE, IDX_HIGH_LIVE,
         IDX_CFG_STORED, IDX_LOW_STORED, IDX_HIGH_STORED: idx_valid = 1'b1;
         default: idx_valid = 1'b0;
      endcase
   endfunction : idx_valid

   // selected register word for reads
   logic [15:0] sel_word;
   always_comb begin
      case (index_reg)
         IDX_CFG_LIVE: sel_word = live_reg.config_live;
         IDX_LOW_LIVE: sel_word = live_reg.low_limit_live;
         IDX_HIGH_LIVE: sel_word = live_reg.high_limit_live;
         IDX_CFG_STORED: sel_word = stored_reg.config_live;
         IDX_LOW_STORED: sel_word = stored_reg.low_limit_live;
         IDX_HIGH_STORED: sel_word = stored_reg.high_limit_live;
         default: sel_word = temp_reg;
      endcase
   end

   // a data byte is taken only for a writable index with no lock
   logic data_ok;
   // [RULE_21] temperature index refuses data
   assign data_ok = !i_lock && (index_reg != IDX_TEMP);

   // -----------------------------------------------------------------
   // pin sampling
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= i_scl;
         sda_q_reg <= i_sda;
      end
   end

   // -----------------------------------------------------------------
   // serial engine
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         cnt_reg <= CNT_ZERO;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         hi_reg <= 1'b1;
         oe_reg <= 1'b0;
         sda_out_reg <= 1'b0;
      end else if (stop_ev) begin
         // stop releases the line and ends the frame
         state_reg <= ST_IDLE;
         oe_reg <= 1'b0;
      end else if (start_ev) begin
         // start or repeated start begins an address byte
         // [RULE_16] frame opens with address byte
         state_reg <= ST_ADDR;
         cnt_reg <= CNT_ZERO;
         oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], i_sda};
                  cnt_reg <= cnt_reg + CNT_ONE;
               end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                  // [RULE_18] acknowledge only our address
                  if (addr_match) begin
                     oe_reg <= 1'b1;
                     rw_reg <= shift_reg[0];
                     state_reg <= ST_ADDR_ACK;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_reg <= CNT_ZERO;
                  hi_reg <= 1'b1;
                  if (rw_reg) begin
                     // [RULE_20] read sends upper byte first
                     tx_reg <= sel_word[15:8];
                     oe_reg <= !sel_word[15];
                     state_reg <= ST_TX;
                  end else begin
                     // [RULE_11] first write byte is the index
                     first_reg <= 1'b1;
                     oe_reg <= 1'b0;
                     state_reg <= ST_RX;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], i_sda};
                  cnt_reg <= cnt_reg + CNT_ONE;
               end else if (byte_done) begin
                  first_reg <= 1'b0;
                  state_reg <= ST_RX_ACK;
                  // [RULE_15] bad index or refused data gets NACK
                  oe_reg <= first_reg ? idx_valid(shift_reg) : data_ok;
                  if (!first_reg) begin
                     hi_reg <= !hi_reg;
                  end
               end
            end
            ST_RX_ACK: begin
               // release after the ninth clock and take the next byte
               if (scl_fall) begin
                  oe_reg <= 1'b0;
                  cnt_reg <= CNT_ZERO;
                  state_reg <= ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt_reg == TX_LAST_BIT) begin
                     // hand the line over for the master's answer
                     oe_reg <= 1'b0;
                     state_reg <= ST_TX_ACK;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     oe_reg <= !tx_reg[6];
                     cnt_reg <= cnt_reg + CNT_ONE;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise && i_sda) begin
                  // nack ends the read; wait for stop or start
                  state_reg <= ST_IDLE;
               end else if (scl_fall) begin
                  // ack: lower byte next, then the word again
                  cnt_reg <= CNT_ZERO;
                  hi_reg <= !hi_reg;
                  tx_reg <= hi_reg ? sel_word[7:0] : sel_word[15:8];
                  oe_reg <= hi_reg ? !sel_word[7] : !sel_word[15];
                  state_reg <= ST_TX;
               end
            end
            default: begin
               oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // select index
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         // [RULE_07] index points at temperature
         index_reg <= IDX_RESET;
         // [RULE_09] reads never move the index
      end else if (byte_done && first_reg && idx_valid(shift_reg)) begin
         // [RULE_14] only listed codes replace the index
         index_reg <= shift_reg;
      end
   end

   // upper-bit bytes pass out as commands for other logic
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cmd_valid_reg <= 1'b0;
         cmd_code_reg <= 8'h00;
      end else begin
         // [RULE_13] nonzero upper bits offered as command
         cmd_valid_reg <= byte_done && first_reg && (shift_reg[7:5] != IDX_UPPER_ZERO);
         if (byte_done && first_reg) begin
            cmd_code_reg <= shift_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // data registers; writes land per byte, upper first
   // -----------------------------------------------------------------
   logic [15:0] wr_word;
   always_comb begin
      wr_word = sel_word;
      if (hi_reg) begin
         wr_word[15:8] = shift_reg;
      end else begin
         wr_word[7:0] = shift_reg;
      end
   end

   logic wr_en;
   // [RULE_03] lock blocks both copies
   assign wr_en = byte_done && !first_reg && data_ok;

   always_ff @(posedge i_sys_clk) begin
      if (!i_por_n) begin
         // stored copies only reload factory values on power-on, not on plain reset
         stored_reg <= '{CFG_FACTORY, LOW_FACTORY, HIGH_FACTORY};
      end else if (wr_en) begin
         // [RULE_22] byte-wise update of stored copy
         if (index_reg == IDX_CFG_STORED) stored_reg.config_live <= wr_word;
         if (index_reg == IDX_LOW_STORED) stored_reg.low_limit_live <= wr_word;
         if (index_reg == IDX_HIGH_STORED) stored_reg.high_limit_live <= wr_word;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         // [RULE_02] live copies reload from stored
         live_reg <= stored_reg;
      end else if (wr_en) begin
         // [RULE_08] upper-byte write alone is complete
         if (index_reg == IDX_CFG_LIVE) live_reg.config_live <= wr_word;
         if (index_reg == IDX_LOW_LIVE) live_reg.low_limit_live <= wr_word;
         if (index_reg == IDX_HIGH_LIVE) live_reg.high_limit_live <= wr_word;
      end
   end

   // temperature: a new result that arrives during a read of it is dropped, not held
   logic temp_busy;
   assign temp_busy = (state_reg == ST_TX || state_reg == ST_TX_ACK) && (index_reg == IDX_TEMP);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         temp_reg <= TEMP_RESET;
      end else if (i_temp_valid && !temp_busy) begin
         temp_reg <= i_temp_data;
      end
   end

   // one conversion after reset, even if configured shut down
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         conv_first_reg <= 1'b1;
         conv_reg <= 1'b0;
      end else begin
         // [RULE_19] single pulse after release
         conv_reg <= conv_first_reg;
         conv_first_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // [RULE_04] monitoring sees live copies only
   assign o_live = live_reg;
   assign o_sda_oe = oe_reg;
   assign o_sda_out = sda_out_reg;
   assign o_conv_start = conv_reg;
   assign o_cmd_valid = cmd_valid_reg;
   assign o_cmd_code = cmd_code_reg;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_addr_end;
      state_reg == ST_ADDR && scl_fall && cnt_reg == BITS_PER_BYTE && !start_ev && !stop_ev;
   endsequence
   a_reset_index: assert property (@(posedge i_sys_clk) !i_rst_n |=> index_reg == IDX_RESET) // [RULE_07]
      else $error("index not cleared by reset");
   a_reset_live: assert property (@(posedge i_sys_clk) disable iff (!i_por_n)
      !i_rst_n |=> live_reg == $past(stored_reg)) // [RULE_02]
      else $error("live copy not loaded from stored");
   a_addr_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_addr_end and addr_match |=> o_sda_oe && state_reg == ST_ADDR_ACK) // [RULE_18]
      else $error("matching address not acknowledged");
   a_addr_miss: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      s_addr_end and !addr_match |=> !o_sda_oe && state_reg == ST_IDLE) // [RULE_17]
      else $error("foreign address acknowledged");
   a_index_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      byte_done && first_reg && !stop_ev && !start_ev && idx_valid(shift_reg)
      |=> index_reg == $past(shift_reg) && o_sda_oe) // [RULE_11]
      else $error("valid index byte not taken");
   a_index_bad: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      byte_done && first_reg && !stop_ev && !start_ev && !idx_valid(shift_reg)
      |=> $stable(index_reg) && !o_sda_oe) // [RULE_15]
      else $error("invalid index byte not refused");
   a_temp_nack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      byte_done && !first_reg && !stop_ev && !start_ev && index_reg == IDX_TEMP
      |=> !o_sda_oe && $stable(temp_reg) || $past(i_temp_valid)) // [RULE_21]
      else $error("write to temperature accepted");
   a_lock_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !i_por_n)
      byte_done && i_lock |=> $stable(stored_reg) && $stable(live_reg)) // [RULE_03]
      else $error("locked register changed");
   a_conv_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !$past(i_rst_n) |=> o_conv_start ##1 !o_conv_start) // [RULE_19]
      else $error("missing conversion after reset");
   a_read_upper: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      state_reg == ST_ADDR_ACK && scl_fall && rw_reg && !start_ev && !stop_ev
      |=> o_sda_oe == !$past(sel_word[15])) // [RULE_20]
      else $error("read did not start with upper bit");
endmodule : tsr_regs
`default_nettype wire

/* File: verification/tsr_i2c_master.sv */
// two-wire bus master model that drives the sensor's clock and data lines
`timescale 1ns/1ns
`default_nettype none
module tsr_i2c_master (
   // clock
   input wire logic i_sys_clk,
   // bus lines, data is open drain with a pull-up
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   // bus idles released with the clock high
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // -----------------------------------------------------------------
   // bit level
   // -----------------------------------------------------------------
   // data changes only while the clock is low, sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic r);
      repeat (2) @(posedge i_sys_clk);
      o_sda_oe <= ~b;
      repeat (3) @(posedge i_sys_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      r = i_sda;
      o_scl <= 1'b0;
   endtask : bit_io
   // start before address
   // start or repeated start: data falls while the clock is high
   task automatic start_cond();
      repeat (2) @(posedge i_sys_clk);
      o_sda_oe <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_sda_oe <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_scl <= 1'b0;
   endtask : start_cond
   // stop: data rises while the clock is high, clock then stands high
   task automatic stop_cond();
      repeat (2) @(posedge i_sys_clk);
      o_sda_oe <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      o_scl <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_sda_oe <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
   endtask : stop_cond
   // -----------------------------------------------------------------
   // byte level
   // -----------------------------------------------------------------
   // byte out, then the device's acknowledge
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = (r === 1'b0);
   endtask : write_byte
   // byte in, msb first; master acknowledges when more bytes are wanted
   task automatic read_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~more, r);
   endtask : read_byte
endmodule : tsr_i2c_master
`default_nettype wire

/* File: verification/tsr_regs_test.sv */
// self-checking bench of the sensor register map, driven through a bus master model
`timescale 1ns/1ns
`default_nettype none
module tsr_regs_test;
   import tsr_pkg::*;
   // -----------------------------------------------------------------
   // design inputs, bus wire and observers
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic [2:0] straps = 3'h5;
   logic lock = 1'b0;
   logic [15:0] temp_data = 16'h0000;
   logic temp_valid = 1'b0;
   logic scl;
   logic mst_oe;
   logic sda_out;
   logic sda_oe;
   logic sda;
   logic conv_start;
   tsr_live_t live;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic [7:0] last_cmd = 8'h00;
   int conv_count = 0;
   int num_errors = 0;
   int n_tests = 0;
   // open-drain wire: either party pulls low, pull-up otherwise
   assign sda = (sda_oe ? sda_out : 1'b1) & ~mst_oe;
   initial begin
      forever #4 clk = ~clk;
   end
   tsr_regs tsr_regs_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_strapped_address_inputs(straps), .i_lock(lock), .i_temp_data(temp_data),
      .i_temp_valid(temp_valid), .o_conv_start(conv_start), .o_live(live),
      .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code));
   tsr_i2c_master tsr_i2c_master_inst (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(mst_oe));
   // pulses are one cycle wide, so they are caught here rather than by polling
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) last_cmd <= cmd_code;
      if (conv_start === 1'b1) conv_count <= conv_count + 1;
   end
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // every write frame carries a fresh index byte first
   task automatic wr_frame(input logic [7:0] idx, input logic [15:0] val, input int nb,
                           output logic a_idx, output logic a_dat);
      logic a;
      tsr_i2c_master_inst.start_cond();
      tsr_i2c_master_inst.write_byte({ADDR_PREFIX, straps, 1'b0}, a);
      check(16'(a), 16'h0001);
      tsr_i2c_master_inst.write_byte(idx, a_idx);
      a_dat = 1'b1;
      for (int i = 0; i < nb; i++) begin
         tsr_i2c_master_inst.write_byte(i[0] ? val[7:0] : val[15:8], a);
         a_dat &= a;
      end
      tsr_i2c_master_inst.stop_cond();
   endtask : wr_frame
   // read frame of one or two bytes; a single byte leaves the lower half zero
   task automatic rd_frame(input int nb, output logic [15:0] val);
      logic a;
      val = 16'h0000;
      tsr_i2c_master_inst.start_cond();
      tsr_i2c_master_inst.write_byte({ADDR_PREFIX, straps, 1'b1}, a);
      check(16'(a), 16'h0001);
      tsr_i2c_master_inst.read_byte(nb > 1, val[15:8]);
      if (nb > 1) tsr_i2c_master_inst.read_byte(1'b0, val[7:0]);
      tsr_i2c_master_inst.stop_cond();
   endtask : rd_frame
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   // power-up values, first conversion, reads without loading the index
   task automatic sc_power_up();
      logic [15:0] v;
      check(live.config_live, CFG_FACTORY);
      check(live.low_limit_live, LOW_FACTORY);
      check(live.high_limit_live, HIGH_FACTORY);
      check(16'(conv_count), 16'h0001);
      rd_frame(2, v);
      check(v, TEMP_RESET);
      temp_data <= 16'h1940;
      temp_valid <= 1'b1;
      @(posedge clk);
      temp_valid <= 1'b0;
      rd_frame(2, v);
      check(v, 16'h1940);
      rd_frame(1, v);
      check(v, 16'h1900);
   endtask : sc_power_up
   // wrong prefix or wrong strap bits are not acknowledged
   task automatic sc_address();
      logic a;
      logic [15:0] v;
      logic [7:0] bad [2] = '{{4'h8, straps, 1'b0}, {ADDR_PREFIX, straps ^ 3'h1, 1'b0}};
      for (int k = 0; k < 2; k++) begin
         tsr_i2c_master_inst.start_cond();
         tsr_i2c_master_inst.write_byte(bad[k], a);
         check(16'(a), 16'h0000);
         tsr_i2c_master_inst.stop_cond();
      end
      // moved straps must move the answered address
      straps <= 3'h2;
      rd_frame(1, v);
      check(v, 16'h1900);
      straps <= 3'h5;
   endtask : sc_address
   // every writable code written, reselected and read back
   task automatic sc_regs();
      logic ai;
      logic ad;
      logic [15:0] v;
      logic [15:0] wv;
      logic [7:0] idx [6] = '{IDX_CFG_LIVE, IDX_LOW_LIVE, IDX_HIGH_LIVE,
                               IDX_CFG_STORED, IDX_LOW_STORED, IDX_HIGH_STORED};
      for (int k = 0; k < 6; k++) begin
         wv = {idx[k], 8'h5A ^ idx[k]};
         wr_frame(idx[k], wv, 2, ai, ad);
         check(16'({ai, ad}), 16'h0003);
         wr_frame(idx[k], 16'h0000, 0, ai, ad);
         rd_frame(2, v);
         check(v, wv);
      end
      check(live.config_live, 16'h015B);
      check(live.low_limit_live, 16'h0258);
      check(live.high_limit_live, 16'h0359);
   endtask : sc_regs
   // invalid index bytes refused, index kept, command byte reported
   task automatic sc_invalid();
      logic ai;
      logic ad;
      logic [15:0] v;
      logic [7:0] bad [3] = '{8'h04, 8'h10, 8'h21};
      wr_frame(IDX_LOW_LIVE, 16'h0000, 0, ai, ad);
      for (int k = 0; k < 3; k++) begin
         wr_frame(bad[k], 16'h0000, 0, ai, ad);
         check(16'(ai), 16'h0000);
      end
      rd_frame(2, v);
      check(v, 16'h0258);
      check(16'(last_cmd), 16'h0021);
   endtask : sc_invalid
   // temperature writes, locked writes, upper-byte-only writes
   task automatic sc_refused();
      logic ai;
      logic ad;
      logic [15:0] v;
      wr_frame(IDX_TEMP, 16'hFFFF, 2, ai, ad);
      check(16'({ai, ad}), 16'h0002);
      rd_frame(2, v);
      check(v, 16'h1940);
      lock <= 1'b1;
      wr_frame(IDX_CFG_LIVE, 16'hC3C3, 2, ai, ad);
      check(16'(ad), 16'h0000);
      check(live.config_live, 16'h015B);
      lock <= 1'b0;
      wr_frame(IDX_CFG_LIVE, 16'hA700, 1, ai, ad);
      check(live.config_live, 16'hA75B);
      rd_frame(1, v);
      check(v, 16'hA700);
   endtask : sc_refused
   // plain reset reloads live copies from the written stored copies
   task automatic sc_rerst();
      logic [15:0] v;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check(live.config_live, 16'h114B);
      check(live.low_limit_live, 16'h1248);
      check(live.high_limit_live, 16'h1349);
      check(16'(conv_count), 16'h0002);
      rd_frame(2, v);
      check(v, TEMP_RESET);
   endtask : sc_rerst
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (6) @(posedge clk);
      sc_power_up();
      sc_address();
      sc_regs();
      sc_invalid();
      sc_refused();
      sc_rerst();
      give_verdict();
   end
   // a hang counts as a mismatch and ends the run
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("BAD at %0t: run did not finish", $time);
      give_verdict();
   end
endmodule : tsr_regs_test
`default_nettype wire
